// file: test/tb_top.sv
// self-checking bench for the instruction executor over axi4-lite
`timescale 1ns/1ps
`include "mmie_cfg.svh"
module tb_top
  import mmie_pkg::*;
  ;
  // clock, reset and bus signals
  logic        clk_sys_in;
  logic        resetn_in;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        busy_out;
  int unsigned num_errors;
  int unsigned checks_done;
  int unsigned run_len;
  int unsigned last_len;
  logic [31:0] rd;
  logic [1:0]  rs;

  mmie_exec mmie_exec_i
  (
    .clk_sys_in        (clk_sys_in),
    .resetn_in         (resetn_in),
    .s_axi_awaddr_in   (awaddr),
    .s_axi_awvalid_in  (awvalid),
    .s_axi_awready_out (awready),
    .s_axi_wdata_in    (wdata),
    .s_axi_wstrb_in    (wstrb),
    .s_axi_wvalid_in   (wvalid),
    .s_axi_wready_out  (wready),
    .s_axi_bresp_out   (bresp),
    .s_axi_bvalid_out  (bvalid),
    .s_axi_bready_in   (bready),
    .s_axi_araddr_in   (araddr),
    .s_axi_arvalid_in  (arvalid),
    .s_axi_arready_out (arready),
    .s_axi_rdata_out   (rdata),
    .s_axi_rresp_out   (rresp),
    .s_axi_rvalid_out  (rvalid),
    .s_axi_rready_in   (rready),
    .busy_out          (busy_out)
  );

  // 10 MHz clock
  always #50 clk_sys_in = ~clk_sys_in;

  // length of each busy run, used to see one instruction cycle
  always @(posedge clk_sys_in)
  begin
    if (busy_out === 1'b1)
      run_len++;
    else if (run_len != 0)
    begin
      last_len = run_len;
      run_len  = 0;
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // a wait that runs out counts as a mismatch and ends the run
  task automatic give_up();
    num_errors++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    report_and_stop();
  endtask : give_up

  // aw and w offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    @(posedge clk_sys_in);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys_in);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      give_up();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    @(posedge clk_sys_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys_in);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      give_up();
  endtask : axi_read

  // read a register and compare data and an okay response
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, rs);
    check({30'h0, rs}, {30'h0, `MMIE_RESP_OKAY});
    check(rd, exp);
  endtask : expect_reg

  // issue one instruction and wait for its cycle to end
  task automatic exec(input logic [15:0] instr);
    int n;
    axi_write(`MMIE_OFS_INSTR, {16'h0, instr}, rs);
    check({30'h0, rs}, {30'h0, `MMIE_RESP_OKAY});
    for (n = 0; n < 20 && busy_out !== 1'b0; n++)
      @(posedge clk_sys_in);
    if (n == 20)
      give_up();
    @(posedge clk_sys_in);
  endtask : exec

  task automatic poke(input logic [7:0] a, input logic [7:0] v);
    axi_write(`MMIE_OFS_FILE_ADDR, {24'h0, a}, rs);
    axi_write(`MMIE_OFS_FILE_DATA, {24'h0, v}, rs);
  endtask : poke

  task automatic expect_file(input logic [7:0] a, input logic [7:0] v);
    axi_write(`MMIE_OFS_FILE_ADDR, {24'h0, a}, rs);
    expect_reg(`MMIE_OFS_FILE_DATA, {24'h0, v});
  endtask : expect_file

  // expected zero flag image in the status word
  function automatic logic [31:0] zst(input logic z);
    return {30'h0, z, 1'b0};
  endfunction : zst

  initial
  begin
    clk_sys_in = 1'b0;
    resetn_in  = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    num_errors = 0;
    checks_done = 0;
    run_len = 0;
    last_len = 0;
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    // reset values and an unmapped place
    expect_reg(`MMIE_OFS_ACCUM, 32'h0);
    expect_reg(`MMIE_OFS_BANK, 32'h0);
    expect_reg(`MMIE_OFS_PRODUCT, 32'h0);
    axi_read(8'h1c, rd, rs);
    check({30'h0, rs}, {30'h0, `MMIE_RESP_SLVERR});
    $display("test reset done");
    exec(16'hb0e2);
    expect_reg(`MMIE_OFS_ACCUM, 32'h0000_00e2); // literal load
    check(last_len, 32'h4); // one cycle of four phases
    expect_reg(`MMIE_OFS_STATUS, zst(1'b0)); // flags kept
    exec(16'hbcc4);
    expect_reg(`MMIE_OFS_PRODUCT, 32'h0000_ad08); // product
    expect_reg(`MMIE_OFS_ACCUM, 32'h0000_00e2); // accum kept
    check(last_len, 32'h4); // multiply in one cycle
    $display("test literal and multiply done");
    // bank high nibble, both values of the don't-care bit
    exec(16'hba5f);
    expect_reg(`MMIE_OFS_BANK, 32'h0000_0050); // high nibble
    exec(16'hbb3c);
    expect_reg(`MMIE_OFS_BANK, 32'h0000_0030); // bit 8 ignored
    $display("test bank done");
    // store into the top of the file space, then copies
    exec(16'h01ff);
    expect_file(8'hff, 8'he2); // store anywhere
    expect_reg(`MMIE_OFS_STATUS, zst(1'b0)); // flags kept
    poke(8'h1f, 8'h00);
    exec(16'h5f20);
    expect_file(8'h20, 8'h00); // zero copied
    expect_reg(`MMIE_OFS_STATUS, zst(1'b1)); // zero flag set
    exec(16'hbcc4);
    expect_reg(`MMIE_OFS_STATUS, zst(1'b1)); // flag kept on multiply
    exec(16'hbc00);
    expect_reg(`MMIE_OFS_PRODUCT, 32'h0); // zero product
    poke(8'h1f, 8'h77);
    exec(16'h5fc0);
    expect_file(8'hc0, 8'h77); // top source
    expect_reg(`MMIE_OFS_STATUS, zst(1'b0)); // zero flag cleared
    exec(16'hbc00);
    expect_reg(`MMIE_OFS_STATUS, zst(1'b0)); // zero not raised
    // accumulator as source and as destination
    exec(16'h4a30);
    expect_file(8'h30, 8'he2); // accum as source
    exec(16'h5f0a);
    expect_reg(`MMIE_OFS_ACCUM, 32'h0000_0077); // accum as target
    $display("test copy done");
    // pointer0 set by a store, then indirect source and destination
    exec(16'hb080);
    exec(16'h0101);
    poke(8'h80, 8'h3c);
    exec(16'h4040);
    expect_file(8'h40, 8'h3c); // indirect source
    exec(16'h5f00);
    expect_file(8'h80, 8'h77); // indirect destination
    $display("test indirect done");
    // second issue while busy is refused, then cleared
    axi_write(`MMIE_OFS_INSTR, 32'h0000_b011, rs);
    axi_write(`MMIE_OFS_INSTR, 32'h0000_b022, rs);
    check({30'h0, rs}, {30'h0, `MMIE_RESP_SLVERR}); // one at a time
    exec(16'hffff);
    expect_reg(`MMIE_OFS_ACCUM, 32'h0000_0011); // refused word dropped
    axi_read(`MMIE_OFS_STATUS, rd, rs);
    check(rd & 32'hc, 32'hc); // refusal flagged
    axi_write(`MMIE_OFS_STATUS, 32'h8, rs);
    axi_read(`MMIE_OFS_STATUS, rd, rs);
    check(rd & 32'h8, 32'h0); // refusal flag cleared
    axi_write(8'h1c, 32'h0, rs);
    check({30'h0, rs}, {30'h0, `MMIE_RESP_SLVERR});
    $display("test refusal done");
    report_and_stop();
  end
endmodule : tb_top

// file: verilog/mmie_cfg.svh
// offsets, field positions, opcodes and reset values of the executor
`ifndef MMIE_CFG_SVH
`define MMIE_CFG_SVH

// register byte offsets on the control bus
`define MMIE_OFS_INSTR      8'h00
`define MMIE_OFS_STATUS     8'h04
`define MMIE_OFS_ACCUM      8'h08
`define MMIE_OFS_BANK       8'h0c
`define MMIE_OFS_PRODUCT    8'h10
`define MMIE_OFS_FILE_ADDR  8'h14
`define MMIE_OFS_FILE_DATA  8'h18

// status register bit positions
`define MMIE_ST_BUSY        0
`define MMIE_ST_ZERO        1
`define MMIE_ST_ILLEGAL     2
`define MMIE_ST_REFUSED     3

// bus responses
`define MMIE_RESP_OKAY      2'b00
`define MMIE_RESP_SLVERR    2'b10

// opcode fields of the 16-bit instruction word
`define MMIE_OPC_BANK_HIGH  7'h5d
`define MMIE_OPC_LIT_ACCUM  8'hb0
`define MMIE_OPC_STORE      8'h01
`define MMIE_OPC_MULTIPLY   8'hbc
`define MMIE_OPC_COPY       3'h2

// mapped locations of the file space
`define MMIE_ADDR_INDIRECT0 8'h00
`define MMIE_ADDR_POINTER0  8'h01
`define MMIE_ADDR_INDIRECT1 8'h08
`define MMIE_ADDR_POINTER1  8'h09
`define MMIE_ADDR_ACCUM     8'h0a

// reset values
`define MMIE_RST_BYTE       8'h00
`define MMIE_RST_WORD       16'h0000

`endif

// file: verilog/mmie_exec.sv
// executor for five one-word instructions, driven over axi4-lite
`timescale 1ns/1ps
`include "mmie_cfg.svh"
module mmie_exec
  import mmie_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // execution state
  output logic             busy_out
);

  mmie_phase_t phase_reg;
  mmie_op_t    op_reg;
  mmie_op_t    op_next;
  logic [15:0] instr_reg;
  logic [7:0]  opnd_reg;
  logic [7:0]  dst_reg;
  logic [15:0] prod_tmp_reg;
  logic [15:0] prod_comb;
  logic [7:0]  accum_reg;
  logic [7:0]  bank_select_reg;
  logic [7:0]  product_high_reg;
  logic [7:0]  product_low_reg;
  logic [7:0]  fsr0_reg;
  logic [7:0]  fsr1_reg;
  logic        zero_reg;
  logic        illegal_reg;
  logic        refused_reg;
  logic [7:0]  file_addr_reg;
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        do_write;
  logic        issue;
  logic        refuse;
  logic        poke;
  logic        busy;
  logic [7:0]  src_addr;
  logic [7:0]  exec_raddr;
  logic [7:0]  exec_rdata;
  logic [7:0]  dbg_rdata;
  logic [7:0]  file_value;
  logic [7:0]  dbg_value;
  logic        file_we;
  logic [7:0]  file_waddr;
  logic [7:0]  file_wdata;
  logic        mem_we;

  // an indirect location stands for the byte its pointer names
  function automatic logic [7:0] resolve(input logic [7:0] a,
                                         input logic [7:0] p0,
                                         input logic [7:0] p1);
    logic [7:0] r;
    r = a;
    if (a == `MMIE_ADDR_INDIRECT0)
      r = p0;
    else if (a == `MMIE_ADDR_INDIRECT1)
      r = p1;
    return r;
  endfunction : resolve

  // bus handshakes; a channel stalls while its item is held
  assign busy              = (phase_reg != ST_IDLE);
  assign busy_out          = busy;
  assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_out  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rdata_out   = rdata_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  // a new instruction is only taken between instruction cycles
  assign issue  = do_write && (aw_addr_reg == `MMIE_OFS_INSTR) && !busy
                  && (w_strb_reg[1:0] == 2'b11);
  assign refuse = do_write && (aw_addr_reg == `MMIE_OFS_INSTR) && busy;
  assign poke   = do_write && (aw_addr_reg == `MMIE_OFS_FILE_DATA) && !busy
                  && w_strb_reg[0];

  // write address and data are taken in either order
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= `MMIE_RST_BYTE;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  // write response; unmapped or refused writes answer slverr
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `MMIE_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= `MMIE_RESP_OKAY;
      if (refuse || aw_addr_reg > `MMIE_OFS_FILE_DATA
          || aw_addr_reg[1:0] != 2'b00)
        bresp_reg <= `MMIE_RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      bvalid_reg <= 1'b0;
  end

  // software knobs: file pointer and refusal flag, set wins over clear
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      file_addr_reg <= `MMIE_RST_BYTE;
      refused_reg   <= 1'b0;
    end
    else
    begin
      if (do_write && aw_addr_reg == `MMIE_OFS_FILE_ADDR && w_strb_reg[0])
        file_addr_reg <= w_data_reg[7:0];
      if (refuse)
        refused_reg <= 1'b1;
      else if (do_write && aw_addr_reg == `MMIE_OFS_STATUS
               && w_strb_reg[0] && w_data_reg[`MMIE_ST_REFUSED])
        refused_reg <= 1'b0;
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `MMIE_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `MMIE_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      case (s_axi_araddr_in)
        `MMIE_OFS_INSTR:     rdata_reg[15:0] <= instr_reg;
        `MMIE_OFS_STATUS:    rdata_reg[3:0]  <= {refused_reg, illegal_reg,
                                                 zero_reg, busy};
        `MMIE_OFS_ACCUM:     rdata_reg[7:0]  <= accum_reg;
        `MMIE_OFS_BANK:      rdata_reg[7:0]  <= bank_select_reg;
        `MMIE_OFS_PRODUCT:   rdata_reg[15:0] <= {product_high_reg,
                                                 product_low_reg};
        `MMIE_OFS_FILE_ADDR: rdata_reg[7:0]  <= file_addr_reg;
        `MMIE_OFS_FILE_DATA: rdata_reg[7:0]  <= dbg_value;
        default:             rresp_reg       <= `MMIE_RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready_in)
      rvalid_reg <= 1'b0;
  end

  // one instruction cycle of four phases, no bubble
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      phase_reg <= ST_IDLE;
    else
    begin
      unique case (phase_reg)
        ST_IDLE: phase_reg <= issue ? ST_Q1 : ST_IDLE;
        ST_Q1:   phase_reg <= ST_Q2;
        ST_Q2:   phase_reg <= ST_Q3;
        ST_Q3:   phase_reg <= ST_Q4;
        ST_Q4:   phase_reg <= ST_IDLE;
        default: phase_reg <= ST_IDLE;
      endcase
    end
  end

  // decode; copy has a 3-bit prefix, bank-high ignores bit 8
  always_comb
  begin
    op_next = OP_NONE;
    if (instr_reg[15:13] == `MMIE_OPC_COPY)
      op_next = OP_COPY;
    else if (instr_reg[15:9] == `MMIE_OPC_BANK_HIGH)
      op_next = OP_LBH;
    else if (instr_reg[15:8] == `MMIE_OPC_LIT_ACCUM)
      op_next = OP_LIT;
    else if (instr_reg[15:8] == `MMIE_OPC_STORE)
      op_next = OP_STORE;
    else if (instr_reg[15:8] == `MMIE_OPC_MULTIPLY)
      op_next = OP_MUL;
  end

  // copy source is the 5-bit field, zero extended
  assign src_addr   = resolve({3'h0, instr_reg[12:8]}, fsr0_reg, fsr1_reg);
  assign exec_raddr = src_addr;
  // mapped locations read from their own registers
  always_comb
  begin
    if (exec_raddr == `MMIE_ADDR_ACCUM)
      file_value = accum_reg;
    else if (exec_raddr == `MMIE_ADDR_POINTER0)
      file_value = fsr0_reg;
    else if (exec_raddr == `MMIE_ADDR_POINTER1)
      file_value = fsr1_reg;
    else
      file_value = exec_rdata;
    if (file_addr_reg == `MMIE_ADDR_ACCUM)
      dbg_value = accum_reg;
    else if (file_addr_reg == `MMIE_ADDR_POINTER0)
      dbg_value = fsr0_reg;
    else if (file_addr_reg == `MMIE_ADDR_POINTER1)
      dbg_value = fsr1_reg;
    else
      dbg_value = dbg_rdata;
  end

  // q1 decodes, q2 reads operand, q3 processes
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      instr_reg    <= `MMIE_RST_WORD;
      op_reg       <= OP_NONE;
      illegal_reg  <= 1'b0;
      opnd_reg     <= `MMIE_RST_BYTE;
      dst_reg      <= `MMIE_RST_BYTE;
      prod_tmp_reg <= `MMIE_RST_WORD;
    end
    else
    begin
      if (issue)
        instr_reg <= w_data_reg[15:0];
      if (phase_reg == ST_Q1)
      begin
        op_reg      <= op_next;
        illegal_reg <= (op_next == OP_NONE);
      end
      if (phase_reg == ST_Q2)
      begin
        // file destination resolved through the pointers
        dst_reg  <= resolve(instr_reg[7:0], fsr0_reg, fsr1_reg);
        opnd_reg <= instr_reg[7:0];
        if (op_reg == OP_COPY)
          opnd_reg <= file_value;
        else if (op_reg == OP_STORE)
          opnd_reg <= accum_reg;
      end
      if (phase_reg == ST_Q3 && op_reg == OP_MUL)
        prod_tmp_reg <= prod_comb;
    end
  end

  // q4 file write-back, or a bus poke between instructions
  assign file_we    = (phase_reg == ST_Q4
                       && (op_reg == OP_COPY || op_reg == OP_STORE)) || poke;
  assign file_waddr = poke ? file_addr_reg : dst_reg;
  assign file_wdata = poke ? w_data_reg[7:0] : opnd_reg;
  assign mem_we     = file_we && file_waddr != `MMIE_ADDR_ACCUM
                      && file_waddr != `MMIE_ADDR_POINTER0
                      && file_waddr != `MMIE_ADDR_POINTER1;

  // accumulator and pointers, written by literal load or file write
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      accum_reg <= `MMIE_RST_BYTE;
      fsr0_reg <= `MMIE_RST_BYTE;
      fsr1_reg <= `MMIE_RST_BYTE;
    end
    else
    begin
      if (phase_reg == ST_Q4 && op_reg == OP_LIT)
        accum_reg <= opnd_reg;
      else if (file_we && file_waddr == `MMIE_ADDR_ACCUM)
        accum_reg <= file_wdata;
      if (file_we && file_waddr == `MMIE_ADDR_POINTER0)
        fsr0_reg <= file_wdata;
      if (file_we && file_waddr == `MMIE_ADDR_POINTER1)
        fsr1_reg <= file_wdata;
    end
  end

  // bank select, product pair and zero flag written in q4
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bank_select_reg  <= `MMIE_RST_BYTE;
      product_high_reg <= `MMIE_RST_BYTE;
      product_low_reg  <= `MMIE_RST_BYTE;
      zero_reg  <= 1'b0;
    end
    else if (phase_reg == ST_Q4)
    begin
      if (op_reg == OP_LBH)
        bank_select_reg[7:4] <= opnd_reg[7:4];
      // high byte and low byte split; no flag touched
      if (op_reg == OP_MUL)
      begin
        product_high_reg <= prod_tmp_reg[15:8];
        product_low_reg  <= prod_tmp_reg[7:0];
      end
      // only the copy sets or clears zero
      if (op_reg == OP_COPY)
        zero_reg <= (opnd_reg == `MMIE_RST_BYTE);
    end
  end

  // file space and multiplier
  mmie_file_mem u_mem
  (
    .clk_sys_in  (clk_sys_in),
    .we_in       (mem_we),
    .waddr_in    (file_waddr),
    .wdata_in    (file_wdata),
    .raddr_a_in  (exec_raddr),
    .rdata_a_out (exec_rdata),
    .raddr_b_in  (file_addr_reg),
    .rdata_b_out (dbg_rdata)
  );

  mmie_mult #(.W(8)) u_mult
  (
    .a_in  (accum_reg),
    .b_in  (opnd_reg),
    .p_out (prod_comb)
  );

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_bank_high_nibble: assert property (
    phase_reg == ST_Q4 && op_reg == OP_LBH |=> bank_select_reg[7:4] ==
      $past(opnd_reg[7:4])
      && bank_select_reg[3:0] == $past(bank_select_reg[3:0]))
    else $error("bank-high load wrote wrong nibble");
  a_bank_high_decode: assert property (
    phase_reg == ST_Q1 && instr_reg[15:9] == `MMIE_OPC_BANK_HIGH
      |=> op_reg == OP_LBH)
    else $error("bank-high prefix not decoded");
  a_single_cycle: assert property (
    phase_reg == ST_Q1 |-> ##3 phase_reg == ST_Q4 ##1 phase_reg == ST_IDLE)
    else $error("instruction cycle not four phases");
  a_phase_order: assert property (
    issue |=> phase_reg == ST_Q1 ##1 phase_reg == ST_Q2
      ##1 phase_reg == ST_Q3)
    else $error("phase order broken");
  a_literal_load: assert property (
    phase_reg == ST_Q4 && op_reg == OP_LIT |=>
      accum_reg == $past(instr_reg[7:0]) && $stable(zero_reg))
    else $error("literal load wrong");
  a_copy_zero: assert property (
    phase_reg == ST_Q4 && op_reg == OP_COPY |=>
      zero_reg == ($past(opnd_reg) == 8'h00))
    else $error("copy zero flag wrong");
  a_copy_source: assert property (
    phase_reg == ST_Q2 && op_reg == OP_COPY
      && instr_reg[12:8] != 5'h00 && instr_reg[12:8] != 5'h08
      |-> exec_raddr[7:5] == 3'h0)
    else $error("copy source out of range");
  a_copy_indirect: assert property (
    phase_reg == ST_Q2 && op_reg == OP_COPY && instr_reg[12:8] == 5'h00
      |-> exec_raddr == fsr0_reg)
    else $error("indirect source not resolved");
  a_store_accum: assert property (
    phase_reg == ST_Q3 && op_reg == OP_STORE |=>
      file_we && file_wdata == accum_reg ##1 $stable(zero_reg))
    else $error("store did not write accumulator");
  a_multiply_pair: assert property (
    phase_reg == ST_Q2 && op_reg == OP_MUL |-> ##3
      {product_high_reg, product_low_reg} ==
      16'($past(accum_reg, 3)) * 16'($past(instr_reg[7:0], 3)))
    else $error("product wrong");
  a_multiply_quiet: assert property (
    phase_reg == ST_Q4 && op_reg == OP_MUL |=>
      $stable(accum_reg) && $stable(zero_reg))
    else $error("multiply changed accumulator or flag");

endmodule : mmie_exec

// file: verilog/mmie_file_mem.sv
// 256-byte file space with one write and two read ports
`timescale 1ns/1ps
module mmie_file_mem
(
  // clock
  input  wire logic       clk_sys_in,
  // write port
  input  wire logic       we_in,
  input  wire logic [7:0] waddr_in,
  input  wire logic [7:0] wdata_in,
  // read port for execution
  input  wire logic [7:0] raddr_a_in,
  output logic      [7:0] rdata_a_out,
  // read port for the control bus
  input  wire logic [7:0] raddr_b_in,
  output logic      [7:0] rdata_b_out
);

  logic [7:0] mem [256];

  // storage has no reset; software initialises what it uses
  always_ff @(posedge clk_sys_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // asynchronous reads keep operand fetch within one phase
  assign rdata_a_out = mem[raddr_a_in];
  assign rdata_b_out = mem[raddr_b_in];

endmodule : mmie_file_mem

// file: verilog/mmie_mult.sv
// unsigned multiplier of two equal-width operands
`timescale 1ns/1ps
module mmie_mult
#(
  parameter int W = 8
)
(
  // operands
  input  wire logic [W-1:0]   a_in,
  input  wire logic [W-1:0]   b_in,
  // full-width product, never overflows
  output logic      [2*W-1:0] p_out
);

  // operands widened first so no product bit is lost
  assign p_out = {{W{1'b0}}, a_in} * {{W{1'b0}}, b_in};

endmodule : mmie_mult

// file: verilog/mmie_pkg.sv
// types shared by the instruction executor
package mmie_pkg;

  // instruction phases, gray coded along idle-q1-q2-q3-q4
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_Q1   = 3'h1,
    ST_Q2   = 3'h3,
    ST_Q3   = 3'h2,
    ST_Q4   = 3'h6
  } mmie_phase_t;

  // decoded operations
  typedef enum logic [2:0]
  {
    OP_NONE  = 3'h0,
    OP_LBH   = 3'h1,
    OP_LIT   = 3'h2,
    OP_COPY  = 3'h3,
    OP_STORE = 3'h4,
    OP_MUL   = 3'h5
  } mmie_op_t;

endpackage : mmie_pkg
